/* logic/gate_spi_pkg.sv */
package gate_spi_pkg;
    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 16;
    localparam logic [3:0] WORD_MASK = 4'hF;
    localparam int DATA_FILTER_LEN = 3;
    localparam int SELECT_FILTER_LEN = 2;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] ERROR_ANSWER_FLAG = 16'h8000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // Odd parity: the whole word must hold an odd number of ones
    function automatic logic odd_ok(input logic [15:0] w);
        odd_ok = ^w;
    endfunction

    // Parity bit that makes bits 15..1 plus the LSB odd
    function automatic logic odd_bit(input logic [14:0] p);
        odd_bit = ~(^p);
    endfunction

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_ACTIVE = 2'b01,
        LINK_CHECK = 2'b10
    } link_state_t;
endpackage

/* logic/glitch_filter.sv */
`timescale 1ns/1ns
// Two-flop synchroniser then a run-length filter of LEN equal samples
module glitch_filter #(
    parameter int LEN = 3,
    parameter logic INIT = 1'b1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    output logic level_o
);
    logic sync_a;
    logic sync_b;
    logic [LEN-1:0] hist;
    wire all_one = &hist;
    wire all_zero = ~(|hist);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_a <= INIT;
            sync_b <= INIT;
            hist <= {LEN{INIT}};
            level_o <= INIT;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            hist <= {hist[LEN-2:0], sync_b};
            if (all_one) begin
                level_o <= 1'b1;
            end else if (all_zero) begin
                level_o <= 1'b0;
            end
        end
    end
endmodule

/* logic/gate_driver_spi_slave.sv */
`timescale 1ns/1ns
// What this block does
// - Slave only, full duplex; never drives serial clock or select.
// - Select low addresses the device; high means not selected.
// - Deselected: ignore clock and data in, data out high impedance.
// - Select falling loads the answer to the previous request.
// - Each rising clock edge shifts one answer bit out, MSB first.
// - Each falling clock edge captures data in into the input register.
// - On deselect, rise/fall counts must match and be multiples of 16.
// - Consistent counts: check the word; bad word is an error, good is decoded.
// - Clock and data in accepted after three equal samples.
// - Parity bit generated in the LSB of every answer word; chained words pass unchanged.
// - Daisy chaining is supported; frames of a multiple of 65536 bits wrap the counters to zero and fail.
// - Select accepted after two equal samples.
// - Odd parity over 16 bits; check on by default, can be disabled.
// - Answer appears one transfer after its request.
// - First word after power-up is answer_payload_i with its parity bit.
module gate_driver_spi_slave
    import gate_spi_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic select_low_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_in_i,
    input wire logic parity_check_enable_i,
    input wire logic [14:0] primary_status_reg_i,
    input wire logic [14:0] answer_payload_i,
    input wire logic answer_valid_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    output logic [14:0] request_payload_o,
    output logic request_strobe_o,
    output logic serial_error_o
);
    logic sel_n;
    logic sck;
    logic serial_data_in;
    logic sck_prev;
    logic sel_prev;
    link_state_t state;
    link_state_t next_state;
    logic [15:0] out_shift;
    logic [15:0] in_shift;
    logic [15:0] answer_word;
    logic last_error;
    logic [CNT_BITS-1:0] rise_cnt;
    logic [CNT_BITS-1:0] fall_cnt;

    // Only the clock domain sampling of the pins; nothing here is driven out
    glitch_filter #(.LEN(SELECT_FILTER_LEN), .INIT(1'b1)) u_sel (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(select_low_i),
        .level_o(sel_n)
    );
    glitch_filter #(.LEN(DATA_FILTER_LEN), .INIT(1'b1)) u_sck (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(serial_clock_i),
        .level_o(sck)
    );
    glitch_filter #(.LEN(DATA_FILTER_LEN), .INIT(1'b1)) u_sdi (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(serial_data_in_i),
        .level_o(serial_data_in)
    );

    wire selected = ~sel_n;
    wire sel_fall = sel_prev & ~sel_n;
    wire sel_rise = ~sel_prev & sel_n;
    wire sck_rise = selected & ~sck_prev & sck;
    wire sck_fall = selected & sck_prev & ~sck;
    wire counts_ok = (rise_cnt == fall_cnt) && ((rise_cnt[3:0] & WORD_MASK) == 4'h0)
        && (rise_cnt != {CNT_BITS{1'b0}});
    wire parity_ok = odd_ok(in_shift) | ~parity_check_enable_i;
    wire word_ok = counts_ok & parity_ok;
    // Error answers carry the status word with the error flag set
    wire [14:0] err_payload = primary_status_reg_i | ERROR_ANSWER_FLAG[15:1];
    wire [14:0] next_payload = last_error ? err_payload : answer_payload_i;
    wire [15:0] next_answer = {next_payload, odd_bit(next_payload)};

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_prev <= 1'b1;
            sel_prev <= 1'b1;
        end else begin
            sck_prev <= sck;
            sel_prev <= sel_n;
        end
    end

    wire start_frame = (state == LINK_IDLE) && sel_fall;
    wire end_frame = (state == LINK_ACTIVE) && sel_rise;
    wire in_frame = (state == LINK_ACTIVE) && !sel_rise;
    wire in_check = (state == LINK_CHECK);
    wire prepare = (state == LINK_IDLE) && !sel_fall;
    wire shift_out = in_frame && sck_rise;
    wire shift_in = in_frame && sck_fall;
    // Clock idles high, so a fall always precedes the rise that forwards its bit
    wire chain_bit = in_shift[0];
    wire [WORD_BITS-1:0] next_out_shift = {out_shift[WORD_BITS-2:0], chain_bit};
    wire [WORD_BITS-1:0] next_in_shift = {in_shift[WORD_BITS-2:0], serial_data_in};

    always_comb begin
        next_state = state;
        unique case (state)
            LINK_IDLE: begin
                if (sel_fall) begin
                    next_state = LINK_ACTIVE;
                end
            end
            LINK_ACTIVE: begin
                if (sel_rise) begin
                    next_state = LINK_CHECK;
                end
            end
            LINK_CHECK: begin
                next_state = LINK_IDLE;
            end
            default: begin
                next_state = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_shift <= ZERO_WORD;
        end else if (start_frame) begin
            out_shift <= answer_word;
        end else if (shift_out) begin
            out_shift <= next_out_shift;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_shift <= ZERO_WORD;
        end else if (shift_in) begin
            in_shift <= next_in_shift;
        end
    end

    // MSB stands from select; each rise then shows the following bit
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_data_out_o <= 1'b0;
        end else if (start_frame) begin
            serial_data_out_o <= answer_word[WORD_BITS-1];
        end else if (shift_out) begin
            serial_data_out_o <= out_shift[WORD_BITS-2];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_data_out_oe_o <= 1'b0;
        end else if (start_frame) begin
            serial_data_out_oe_o <= 1'b1;
        end else if (end_frame || state == LINK_IDLE) begin
            serial_data_out_oe_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_cnt <= '0;
        end else if (start_frame) begin
            rise_cnt <= '0;
        end else if (shift_out) begin
            rise_cnt <= rise_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fall_cnt <= '0;
        end else if (start_frame) begin
            fall_cnt <= '0;
        end else if (shift_in) begin
            fall_cnt <= fall_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            answer_word <= ZERO_WORD;
            last_error <= 1'b0;
            request_payload_o <= '0;
            request_strobe_o <= 1'b0;
            serial_error_o <= 1'b0;
        end else begin
            request_strobe_o <= 1'b0;
            serial_error_o <= 1'b0;
            if (in_check) begin
                last_error <= ~word_ok;
                serial_error_o <= ~word_ok;
                if (word_ok) begin
                    request_payload_o <= in_shift[WORD_BITS-1:1];
                    request_strobe_o <= 1'b1;
                end
            end else if (prepare) begin
                // Prepared between transfers so it is ready at the next select
                answer_word <= next_answer;
                if (answer_valid_i) begin
                    last_error <= 1'b0;
                end
            end
        end
    end
endmodule

/* testbench/gate_driver_spi_slave_sva.sv */
`timescale 1ns/1ns
module gate_driver_spi_slave_sva (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic select_low_i,
    input wire logic serial_data_out_oe_o,
    input wire logic [14:0] request_payload_o,
    input wire logic request_strobe_o,
    input wire logic serial_error_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_drive_when_sel: assert property (!select_low_i [*8] |-> serial_data_out_oe_o)
        else $error("data out not driven");
    a_hiz_when_idle: assert property (select_low_i [*8] |-> !serial_data_out_oe_o)
        else $error("data out driven");
    a_oe_rise_cause: assert property ($rose(serial_data_out_oe_o) |-> !$past(select_low_i, 2))
        else $error("drive without select");
    a_strobe_single: assert property (request_strobe_o |=> !request_strobe_o)
        else $error("long strobe");
    a_error_single: assert property (serial_error_o |=> !serial_error_o)
        else $error("long error");
    a_strobe_at_end: assert property (request_strobe_o |-> $past(select_low_i, 3) && !serial_error_o)
        else $error("early strobe");
    a_error_at_end: assert property (serial_error_o |-> $past(select_low_i, 3))
        else $error("early error");
    a_payload_hold: assert property (!request_strobe_o |-> $stable(request_payload_o))
        else $error("payload moved");
endmodule
bind gate_driver_spi_slave gate_driver_spi_slave_sva i_sva (.clk_i, .arst_n_i, .select_low_i,
    .serial_data_out_oe_o, .request_payload_o, .request_strobe_o, .serial_error_o);

/* testbench/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model (
    input wire logic clk_i,
    input wire logic serial_data_out_i,
    output logic select_low_o,
    output logic serial_clock_o,
    output logic serial_data_in_o
);
    // Idle levels as the pull-ups leave them; clock stands high outside frames
    initial begin
        select_low_o = 1'b1;
        serial_clock_o = 1'b1;
        serial_data_in_o = 1'b1;
    end
    // Half period of 8 clocks, well above the three equal samples the clock and data filters need
    task automatic xfer(input logic [31:0] tx, input int n, input logic sel, output logic [31:0] rx);
        rx = '0;
        select_low_o <= !sel;
        repeat (8) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data_in_o <= tx[i];
            repeat (8) @(posedge clk_i);
            rx = {rx[30:0], serial_data_out_i};
            serial_clock_o <= 1'b0;
            repeat (8) @(posedge clk_i);
            serial_clock_o <= 1'b1;
        end
        repeat (8) @(posedge clk_i);
        select_low_o <= 1'b1;
        serial_data_in_o <= 1'b1;
        repeat (16) @(posedge clk_i);
    endtask
endmodule

/* testbench/gate_driver_spi_slave_tb_top.sv */
`timescale 1ns/1ns
module gate_driver_spi_slave_tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic parity_check_enable_i = 1'b1;
    logic answer_valid_i = 1'b0;
    logic [14:0] primary_status_reg_i, answer_payload_i, request_payload_o;
    logic select_low_i, serial_clock_i, serial_data_in_i, serial_data_out_o, serial_data_out_oe_o;
    logic request_strobe_o, serial_error_o;
    logic [31:0] seed = 32'h9A25;
    logic [15:0] ans_exp;
    logic [15:0] exp_q[$];
    int miscompares = 0;
    int checked = 0;
    int lens[9] = '{16, 16, 16, 16, 16, 15, 0, 32, 16};
    // Wire level seen by the host; floats when not driven
    wire sdo_w = serial_data_out_oe_o ? serial_data_out_o : 1'bz;
    wire [15:0] seen = serial_error_o ? 16'h8000 : {1'b0, request_payload_o};
    always #25 clk_i = ~clk_i;
    gate_driver_spi_slave i_dut (.clk_i, .arst_n_i, .select_low_i, .serial_clock_i, .serial_data_in_i,
        .parity_check_enable_i, .primary_status_reg_i, .answer_payload_i, .answer_valid_i,
        .serial_data_out_o, .serial_data_out_oe_o, .request_payload_o, .request_strobe_o, .serial_error_o);
    spi_host_model i_host (.clk_i(clk_i), .serial_data_out_i(sdo_w), .select_low_o(select_low_i),
        .serial_clock_o(serial_clock_i), .serial_data_in_o(serial_data_in_i));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Note goes in first: the result pulse lands after the host releases but before xfer returns
    task automatic run(input logic [31:0] tx, input int n, input logic bad);
        logic [31:0] rx;
        logic [14:0] nxt;
        @(posedge clk_i);
        answer_valid_i <= 1'b0;
        exp_q.push_back(bad ? 16'h8000 : {1'b0, tx[15:1]});
        i_host.xfer(tx, n, 1'b1, rx);
        if (n >= 16) check("answer", ans_exp, rx[n-1 -: 16]);
        if (n == 32) check("chain", tx[31:16], rx[15:0]);
        seed = lfsr(seed);
        nxt = seed[14:0];
        answer_payload_i <= nxt;
        answer_valid_i <= !bad;
        ans_exp = bad ? {1'b1, primary_status_reg_i[13:0], ~^{1'b1, primary_status_reg_i[13:0]}} : {nxt, ~^nxt};
        $display("test done, %0d bits", n);
    endtask
    always @(posedge clk_i) begin
        if (request_strobe_o === 1'b1 || serial_error_o === 1'b1) begin
            check("result", exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF, seen);
        end
    end
    initial begin
        logic [15:0] w;
        logic [31:0] junk;
        primary_status_reg_i = seed[14:0];
        answer_payload_i = seed[14:0];
        ans_exp = {seed[14:0], ~^seed[14:0]};
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            w = {seed[14:0], ~^seed[14:0]} ^ {15'h0, i == 2 || i == 4};
            parity_check_enable_i <= (i != 4);
            run({seed[31:16], w}, lens[i], i == 2 || i == 5 || i == 6);
        end
        i_host.xfer(32'h5A5A, 16, 1'b0, junk);
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge clk_i);
        if (exp_q.size() > 0) check("pending", 16'h0, 16'hFFFF);
        complete_run();
    end
endmodule
